// [hw/ttr_device.sv]
// Device end: key bytes, temperature and test registers, reset readiness.
`timescale 1ns/100ps
`include "ttr_params.svh"
module ttr_device import ttr_pkg::*; #(
   parameter int READY_CYC = `TTR_READY_CYC,
   parameter int MEAS_CYC = `TTR_MEAS_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   ttr_if.device lnk,
   input wire logic [7:0] sensor_count_i,
   input wire logic low_index_correction_enable_i,
   output logic [23:0] cipher_key_o,
   output logic front_end_gain_mode_o,
   output logic [7:0] fading_margin_mode_o,
   output logic [16:0] freq_offset_hz_o,
   output logic rx_available_o,
   output logic ready_o
);
   logic [7:0] key14_reg, key15_reg, key16_reg, gain_reg, fading_reg, offset_reg;
   logic [7:0] rdata_reg;
   logic rpin_s1_reg, rpin_s2_reg;
   logic [15:0] rdy_cnt_reg;
   logic ready_reg, clock_output_pin_reg;
   logic [1:0] div_reg;
   logic thermo_busy, thermo_start;
   logic [7:0] thermo_reading;
   logic soft_rst;

   // Reset pin passes two flip-flops before use.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rpin_s1_reg <= 1'b0;
         rpin_s2_reg <= 1'b0;
      end else begin
         rpin_s1_reg <= lnk.reset_pin;
         rpin_s2_reg <= rpin_s1_reg;
      end
   end
   assign soft_rst = !rst_n_i || rpin_s2_reg;

   // Readiness counter restarts on any reset; clock output runs once ready.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         rdy_cnt_reg <= 16'h0000;
         ready_reg <= 1'b0;
      end else if (!ready_reg) begin
         if (rdy_cnt_reg == 16'(READY_CYC - 1)) begin
            ready_reg <= 1'b1; // [RULE13]
         end
         rdy_cnt_reg <= rdy_cnt_reg + 16'h0001;
      end
   end

   // Clock output is a divided system clock, quiet until ready.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst || !ready_reg) begin
         div_reg <= 2'h0;
         clock_output_pin_reg <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         if (div_reg == 2'(`TTR_CLOCK_OUTPUT_PIN_DIV / 2 - 1)) begin
            div_reg <= 2'h0;
            clock_output_pin_reg <= !clock_output_pin_reg; // [RULE13]
         end
      end
   end

   // Writable registers; accesses before ready are ignored.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         key14_reg <= `TTR_RST_KEY; // [RULE1]
         key15_reg <= `TTR_RST_KEY;
         key16_reg <= `TTR_RST_KEY;
         gain_reg <= `TTR_RST_GAIN; // [RULE6]
         fading_reg <= `TTR_RST_FADING;
         offset_reg <= `TTR_RST_OFFSET; // [RULE8]
      end else if (lnk.wr && ready_reg) begin
         if (lnk.addr == `TTR_ADDR_KEY14) begin
            key14_reg <= lnk.wdata; // [RULE1]
         end else if (lnk.addr == `TTR_ADDR_KEY15) begin
            key15_reg <= lnk.wdata;
         end else if (lnk.addr == `TTR_ADDR_KEY16) begin
            key16_reg <= lnk.wdata;
         end else if (lnk.addr == `TTR_ADDR_GAIN) begin
            gain_reg <= lnk.wdata; // [RULE6]
         end else if (lnk.addr == `TTR_ADDR_FADING) begin
            fading_reg <= lnk.wdata; // [RULE7]
         end else if (lnk.addr == `TTR_ADDR_OFFSET) begin
            offset_reg <= lnk.wdata; // [RULE8]
         end
      end
   end

   // Trigger is a write-only pulse; a zero bit starts nothing.
   assign thermo_start = lnk.wr && ready_reg && lnk.addr == `TTR_ADDR_THERMO_CTRL
      && lnk.wdata[`TTR_BIT_TRIGGER]; // [RULE2] [RULE14]

   ttr_thermo #(.MEAS_CYC(MEAS_CYC)) u_thermo (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(!soft_rst),
      .start_i(thermo_start),
      .sensor_i(sensor_count_i),
      .busy_o(thermo_busy),
      .reading_o(thermo_reading)
   );

   // Read data one cycle after the strobe; key bytes and unmapped read zero.
   always_ff @(posedge sys_clk_i) begin
      if (soft_rst) begin
         rdata_reg <= 8'h00;
      end else if (lnk.rd && ready_reg) begin
         if (lnk.addr == `TTR_ADDR_THERMO_CTRL) begin
            rdata_reg <= {4'h0, 1'b0, thermo_busy, `TTR_CTRL_LOW_BITS}; // [RULE2] [RULE3]
         end else if (lnk.addr == `TTR_ADDR_THERMO_RESULT) begin
            rdata_reg <= thermo_reading; // [RULE5]
         end else if (lnk.addr == `TTR_ADDR_GAIN) begin
            rdata_reg <= gain_reg;
         end else if (lnk.addr == `TTR_ADDR_FADING) begin
            rdata_reg <= fading_reg;
         end else if (lnk.addr == `TTR_ADDR_OFFSET) begin
            rdata_reg <= offset_reg;
         end else begin
            rdata_reg <= 8'h00; // [RULE1]
         end
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign lnk.rdata = rdata_reg;
   assign lnk.clock_output_pin = clock_output_pin_reg;
   assign cipher_key_o = {key14_reg, key15_reg, key16_reg}; // [RULE1]
   assign front_end_gain_mode_o = (gain_reg == `TTR_GAIN_HIGH); // [RULE6]
   assign fading_margin_mode_o = fading_reg; // [RULE7]
   // Offset applies only with low-index correction enabled.
   // Seventeen bits hold the full product, so a large offset is never wrapped.
   assign freq_offset_hz_o = low_index_correction_enable_i ?
      17'(offset_reg) * 17'(`TTR_OFFSET_STEP_HZ) : 17'h00000; // [RULE8]
   assign rx_available_o = ready_reg && !thermo_busy; // [RULE4]
   assign ready_o = ready_reg;
endmodule

// [hw/ttr_host.sv]
// Host end: waits out reset, drives manual reset, runs register accesses.
`timescale 1ns/100ps
`include "ttr_params.svh"
module ttr_host import ttr_pkg::*; #(
   parameter int POR_WAIT_CYC = `TTR_POR_WAIT_CYC,
   parameter int MAN_WAIT_CYC = `TTR_MAN_WAIT_CYC,
   parameter int PULSE_CYC = `TTR_MAN_PULSE_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   ttr_if.host lnk,
   input wire logic cmd_wr_i,
   input wire logic cmd_rd_i,
   input wire logic cmd_reset_i,
   input wire logic [6:0] cmd_addr_i,
   input wire logic [7:0] cmd_wdata_i,
   output logic cmd_ready_o,
   output logic rdata_valid_o,
   output logic [7:0] rdata_o
);
   ttr_host_state_e state_reg;
   logic [19:0] cnt_reg;
   logic [6:0] addr_reg;
   logic [7:0] wdata_reg, rdata_reg;
   logic valid_reg, ck_s1_reg, ck_s2_reg, ck_s3_reg;

   // Clock output pin synchronised; a seen edge means ready.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ck_s1_reg <= 1'b0;
         ck_s2_reg <= 1'b0;
         ck_s3_reg <= 1'b0;
      end else begin
         ck_s1_reg <= lnk.clock_output_pin;
         ck_s2_reg <= ck_s1_reg;
         ck_s3_reg <= ck_s2_reg;
      end
   end

   // Sequencer; the wait count uses the longer of timer and clock activity.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state_reg <= TTR_H_RESET;
         cnt_reg <= 20'h00000;
         addr_reg <= 7'h00;
         wdata_reg <= 8'h00;
      end else begin
         case (state_reg)
            TTR_H_RESET: begin
               cnt_reg <= 20'(POR_WAIT_CYC - 1); // [RULE9] [RULE10]
               state_reg <= TTR_H_WAIT;
            end
            TTR_H_WAIT: begin
               if (cnt_reg != 20'h00000) begin
                  cnt_reg <= cnt_reg - 20'h00001; // [RULE9] [RULE12]
               end else if (ck_s2_reg != ck_s3_reg) begin
                  state_reg <= TTR_H_IDLE; // [RULE13]
               end
            end
            TTR_H_IDLE: begin
               addr_reg <= cmd_addr_i;
               wdata_reg <= cmd_wdata_i;
               if (cmd_reset_i) begin
                  cnt_reg <= 20'(PULSE_CYC - 1);
                  state_reg <= TTR_H_PULSE; // [RULE11]
               end else if (cmd_wr_i) begin
                  state_reg <= TTR_H_WRITE;
               end else if (cmd_rd_i) begin
                  state_reg <= TTR_H_READ;
               end
            end
            TTR_H_PULSE: begin
               if (cnt_reg == 20'h00000) begin
                  cnt_reg <= 20'(MAN_WAIT_CYC - 1); // [RULE12]
                  state_reg <= TTR_H_WAIT;
               end else begin
                  cnt_reg <= cnt_reg - 20'h00001; // [RULE11]
               end
            end
            default: begin
               state_reg <= TTR_H_IDLE;
            end
         endcase
      end
   end

   // Read data captured the cycle after the read strobe.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 8'h00;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= (state_reg == TTR_H_READ);
         if (state_reg == TTR_H_READ) begin
            rdata_reg <= 8'h00;
         end else if (valid_reg) begin
            rdata_reg <= lnk.rdata;
         end
      end
   end

   assign lnk.addr = addr_reg;
   assign lnk.wdata = wdata_reg;
   assign lnk.wr = (state_reg == TTR_H_WRITE);
   assign lnk.rd = (state_reg == TTR_H_READ);
   assign lnk.reset_pin_o = 1'b1;
   assign lnk.reset_pin_oe = (state_reg == TTR_H_PULSE); // [RULE10] [RULE11]
   assign cmd_ready_o = (state_reg == TTR_H_IDLE);
   assign rdata_valid_o = valid_reg;
   assign rdata_o = valid_reg ? lnk.rdata : rdata_reg;
endmodule

// [hw/ttr_thermo.sv]
// Temperature measurement sequencer with busy flag and result capture.
`timescale 1ns/100ps
`include "ttr_params.svh"
module ttr_thermo import ttr_pkg::*; #(
   parameter int MEAS_CYC = `TTR_MEAS_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [7:0] sensor_i,
   output logic busy_o,
   output logic [7:0] reading_o
);
   logic [15:0] cnt_reg;
   logic busy_reg;
   logic [7:0] reading_reg;

   // Busy stands from start until the count expires; retriggers are ignored.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         busy_reg <= 1'b0;
         cnt_reg <= 16'h0000;
      end else if (!busy_reg && start_i) begin // [RULE2] [RULE14]
         busy_reg <= 1'b1; // [RULE3]
         cnt_reg <= 16'(MEAS_CYC - 1);
      end else if (busy_reg) begin
         if (cnt_reg == 16'h0000) begin
            busy_reg <= 1'b0; // [RULE3]
         end else begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end

   // Result loads only at completion, so a retrigger cannot corrupt it.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reading_reg <= 8'h00;
      end else if (busy_reg && cnt_reg == 16'h0000) begin
         reading_reg <= sensor_i; // [RULE5] [RULE14]
      end
   end

   assign busy_o = busy_reg;
   assign reading_o = reading_reg;
endmodule

// [inc/ttr_if.sv]
// Link between host controller and register bank device.
`timescale 1ns/100ps
interface ttr_if;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic reset_pin_o;
   logic reset_pin_oe;
   logic reset_pin;
   logic clock_output_pin;
   // Undriven reset pin is pulled low by the device.
   assign reset_pin = reset_pin_oe ? reset_pin_o : 1'b0;
   modport host(output addr, output wdata, output wr, output rd, input rdata,
      output reset_pin_o, output reset_pin_oe, input clock_output_pin);
   modport device(input addr, input wdata, input wr, input rd, output rdata,
      input reset_pin, output clock_output_pin);
endinterface

// [inc/ttr_params.svh]
// Constants for the temperature, test register and reset readiness bank.
// Function
// [RULE1] Last three key bytes write-only, reset zero.
// [RULE2] Trigger bit three starts measurement, reads zero.
// [RULE3] Busy bit two high while measuring.
// [RULE4] Receiver unavailable while busy; host waits. ttr_host does not check busy; only the bench waits on rx_available_o.
// [RULE5] Reading falls one count per degree.
// [RULE6] Gain register resets 0x1B, 0x2D boosts.
// [RULE7] Fading margin 0x00 normal, 0x10/0x30 improved.
// [RULE8] Offset equals register times 488 Hz.
// [RULE9] Host waits 10 ms after power-on reset.
// [RULE10] Host leaves reset pin undriven at power-on.
// [RULE11] Manual reset: pin high about 100 us.
// [RULE12] Host waits 5 ms after manual reset.
// [RULE13] Clock output toggling signals device ready.
// [RULE14] Zero trigger ignored; retrigger while busy ignored.
`ifndef TTR_PARAMS_SVH
`define TTR_PARAMS_SVH
`define TTR_ADDR_KEY14 7'h4B
`define TTR_ADDR_KEY15 7'h4C
`define TTR_ADDR_KEY16 7'h4D
`define TTR_ADDR_THERMO_CTRL 7'h4E
`define TTR_ADDR_THERMO_RESULT 7'h4F
`define TTR_ADDR_GAIN 7'h58
`define TTR_ADDR_FADING 7'h6F
`define TTR_ADDR_OFFSET 7'h71
`define TTR_BIT_TRIGGER 3
`define TTR_BIT_BUSY 2
`define TTR_CTRL_LOW_BITS 2'h1
`define TTR_RST_KEY 8'h00
`define TTR_RST_GAIN 8'h1B
`define TTR_GAIN_NORMAL 8'h1B
`define TTR_GAIN_HIGH 8'h2D
`define TTR_RST_FADING 8'h00
`define TTR_FADING_NORMAL 8'h00
`define TTR_FADING_LOW_INDEX_ON 8'h10
`define TTR_FADING_LOW_INDEX_OFF 8'h30
`define TTR_RST_OFFSET 8'h00
`define TTR_OFFSET_STEP_HZ 488
`define TTR_CLK_HZ 10000000
`define TTR_POR_WAIT_MS 10
`define TTR_MAN_WAIT_MS 5
`define TTR_MAN_PULSE_US 100
`define TTR_POR_WAIT_CYC ((`TTR_POR_WAIT_MS * `TTR_CLK_HZ + 999) / 1000)
`define TTR_MAN_WAIT_CYC ((`TTR_MAN_WAIT_MS * `TTR_CLK_HZ + 999) / 1000)
`define TTR_MAN_PULSE_CYC ((`TTR_MAN_PULSE_US * `TTR_CLK_HZ + 999999) / 1000000)
`define TTR_MEAS_CYC 64
`define TTR_READY_CYC 16
`define TTR_CLOCK_OUTPUT_PIN_DIV 4
`endif

// [inc/ttr_pkg.sv]
// Types shared by both ends of the register bank link.
package ttr_pkg;
   typedef enum logic [2:0] {
      TTR_H_RESET = 3'b000,
      TTR_H_WAIT = 3'b001,
      TTR_H_IDLE = 3'b010,
      TTR_H_WRITE = 3'b011,
      TTR_H_READ = 3'b100,
      TTR_H_PULSE = 3'b101
   } ttr_host_state_e;
endpackage

// [tb/temp_test_regs_and_reset_test.sv]
// Self-checking bench for the host and device ends of the register bank link.
`timescale 1ns/100ps
module temp_test_regs_and_reset_test;
   localparam int MEAS = 16;
   localparam int RDY = 4;
   localparam int POR = 20;
   localparam int MANW = 10;
   localparam int PULSE = 4;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cmd_wr_i = 1'b0;
   logic cmd_rd_i = 1'b0;
   logic cmd_reset_i = 1'b0;
   logic [6:0] cmd_addr_i = 7'h00;
   logic [7:0] cmd_wdata_i = 8'h00;
   logic [7:0] sensor_count_i = 8'h80;
   logic low_index_correction_enable_i = 1'b0;
   logic cmd_ready_o, rdata_valid_o, front_end_gain_mode_o, rx_available_o, ready_o;
   logic [7:0] rdata_o, fading_margin_mode_o, v;
   logic [23:0] cipher_key_o;
   logic [16:0] freq_offset_hz_o;
   logic [31:0] rnd = 32'hBB30A670;
   logic [7:0] exp_q[$];
   logic [7:0] k[3];
   logic [7:0] fm[3] = '{8'h00, 8'h10, 8'h30};
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   int low_cnt = 0;
   ttr_if lnk();
   ttr_device #(.READY_CYC(RDY), .MEAS_CYC(MEAS)) u_ttr_device(.sys_clk_i, .rst_n_i,
      .lnk(lnk.device), .sensor_count_i, .low_index_correction_enable_i, .cipher_key_o,
      .front_end_gain_mode_o, .fading_margin_mode_o, .freq_offset_hz_o, .rx_available_o, .ready_o);
   ttr_host #(.POR_WAIT_CYC(POR), .MAN_WAIT_CYC(MANW), .PULSE_CYC(PULSE)) u_ttr_host(.sys_clk_i,
      .rst_n_i, .lnk(lnk.host), .cmd_wr_i, .cmd_rd_i, .cmd_reset_i, .cmd_addr_i, .cmd_wdata_i,
      .cmd_ready_o, .rdata_valid_o, .rdata_o);
   ttr_properties #(.POR_WAIT_CYC(POR), .MAN_WAIT_CYC(MANW), .PULSE_CYC(PULSE)) u_ttr_properties(
      .sys_clk_i, .rst_n_i, .addr(lnk.addr), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata),
      .reset_pin_o(lnk.reset_pin_o), .reset_pin_oe(lnk.reset_pin_oe), .reset_pin(lnk.reset_pin),
      .clock_output_pin(lnk.clock_output_pin));
   // Clock of 100 ns period.
   always #50 sys_clk_i = ~sys_clk_i;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Order is held until the edge that takes it; two spare cycles let the register land.
   task automatic issue(input logic w, r, x, input logic [6:0] a, input logic [7:0] d);
      while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
      {cmd_wr_i, cmd_rd_i, cmd_reset_i, cmd_addr_i, cmd_wdata_i} <= {w, r, x, a, d};
      @(posedge sys_clk_i);
      {cmd_wr_i, cmd_rd_i, cmd_reset_i} <= 3'b000;
      repeat (2) @(negedge sys_clk_i);
   endtask
   task automatic bus_write(input logic [6:0] a, input logic [7:0] d);
      issue(1'b1, 1'b0, 1'b0, a, d);
   endtask
   task automatic bus_read(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      issue(1'b0, 1'b1, 1'b0, a, 8'h00);
   endtask
   // Each returned byte is matched with the oldest noted expectation.
   always @(negedge sys_clk_i) begin
      if (rdata_valid_o === 1'b1) begin
         chk(24'(rdata_o), (exp_q.size() != 0) ? 24'(exp_q.pop_front()) : 24'hFFFFFF);
      end
   end
   // A measurement keeps the receiver off for exactly its length; a retrigger must not stretch it.
   always @(negedge sys_clk_i) begin
      if (ready_o === 1'b1 && rx_available_o === 1'b0) begin
         low_cnt++;
      end else if (low_cnt != 0) begin
         chk(24'(low_cnt), 24'(MEAS));
         low_cnt = 0;
      end
   end
   // Hang guard well beyond the whole sequence.
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(negedge sys_clk_i);
      chk(cipher_key_o, 24'h000000);
      bus_read(7'h58, 8'h1B);
      bus_read(7'h6F, 8'h00);
      bus_read(7'h71, 8'h00);
      bus_read(7'h4E, 8'h01);
      bus_read(7'h7F, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         k[i] = rnd[7:0];
         bus_write(7'h4B + 7'(i), k[i]);
         bus_read(7'h4B + 7'(i), 8'h00);
      end
      chk(cipher_key_o, {k[0], k[1], k[2]});
      bus_write(7'h58, 8'h2D);
      bus_read(7'h58, 8'h2D);
      chk(24'(front_end_gain_mode_o), 24'h000001);
      bus_write(7'h58, 8'h1B);
      chk(24'(front_end_gain_mode_o), 24'h000000);
      for (int i = 0; i < 3; i++) begin
         bus_write(7'h6F, fm[i]);
         bus_read(7'h6F, fm[i]);
         chk(24'(fading_margin_mode_o), 24'(fm[i]));
      end
      rnd = lfsr(rnd);
      v = rnd[7:0];
      bus_write(7'h71, v);
      bus_read(7'h71, v);
      @(posedge sys_clk_i) low_index_correction_enable_i <= 1'b1;
      @(negedge sys_clk_i);
      chk(24'(freq_offset_hz_o), 24'(v) * 24'd488);
      // The largest offset must not wrap in the product.
      bus_write(7'h71, 8'hFF);
      chk(24'(freq_offset_hz_o), 24'd255 * 24'd488);
      @(posedge sys_clk_i) low_index_correction_enable_i <= 1'b0;
      @(negedge sys_clk_i);
      chk(24'(freq_offset_hz_o), 24'h000000);
      // A zero trigger does nothing; the second pass reads one count lower.
      bus_write(7'h4E, 8'h00);
      bus_read(7'h4E, 8'h01);
      for (int i = 0; i < 2; i++) begin
         @(posedge sys_clk_i) sensor_count_i <= v - 8'(i);
         bus_write(7'h4E, 8'h08);
         bus_read(7'h4E, 8'h05);
         bus_write(7'h4E, 8'h08);
         while (rx_available_o !== 1'b1) @(negedge sys_clk_i);
         bus_read(7'h4F, v - 8'(i));
         bus_read(7'h4E, 8'h01);
      end
      // A manual pulse must bring the gain register and the key bytes back to their reset values.
      bus_write(7'h58, 8'h2D);
      issue(1'b0, 1'b0, 1'b1, 7'h00, 8'h00);
      bus_read(7'h58, 8'h1B);
      chk(cipher_key_o, 24'h000000);
      while (exp_q.size() != 0) @(negedge sys_clk_i);
      end_sim();
   end
endmodule

// [tb/ttr_properties.sv]
// Assertions on the host to device register link.
`timescale 1ns/100ps
module ttr_properties #(
   parameter int POR_WAIT_CYC = 20,
   parameter int MAN_WAIT_CYC = 10,
   parameter int PULSE_CYC = 4
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [6:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe,
   input wire logic reset_pin,
   input wire logic clock_output_pin
);
   int por_reg;
   int gap_reg;
   int pulse_reg;
   logic seen_reg;
   logic clk_d_reg;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Cycles since reset release, since the manual pulse ended, and of the pulse itself.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         por_reg <= 0;
         gap_reg <= MAN_WAIT_CYC;
         pulse_reg <= 0;
      end else begin
         por_reg <= (por_reg < POR_WAIT_CYC) ? por_reg + 1 : por_reg;
         gap_reg <= reset_pin_oe ? 0 : ((gap_reg < MAN_WAIT_CYC) ? gap_reg + 1 : gap_reg);
         pulse_reg <= reset_pin_oe ? pulse_reg + 1 : 0;
      end
   end
   // Any clock output edge is the ready sign; a reset pulse forgets it.
   always_ff @(posedge sys_clk_i) begin
      clk_d_reg <= clock_output_pin;
      if (!rst_n_i || reset_pin) begin
         seen_reg <= 1'b0;
      end else if (clock_output_pin != clk_d_reg) begin
         seen_reg <= 1'b1;
      end
   end
   sequence access_s;
      wr || rd;
   endsequence
   sequence read_s(a);
      rd && addr == a;
   endsequence
   strobe_gap_a:
      assert property (access_s |=> !(wr || rd)) else $error("strobes too close");
   rdata_idle_a:
      assert property (!$past(rd) |-> rdata == 8'h00) else $error("stray read data");
   ctrl_read_a:
      assert property (read_s(7'h4E) |=> rdata[7:3] == 5'h00 && rdata[1:0] == 2'h1)
         else $error("control byte reads wrong");
   key_read_a:
      assert property (read_s(7'h4B) or read_s(7'h4C) or read_s(7'h4D) |=> rdata == 8'h00)
         else $error("key byte readable");
   pulse_len_a:
      assert property ($fell(reset_pin_oe) |-> pulse_reg == PULSE_CYC) else $error("pulse length");
   pin_high_a:
      assert property (reset_pin_oe |-> reset_pin_o && reset_pin) else $error("pin not high");
   por_float_a:
      assert property (por_reg < POR_WAIT_CYC |-> !reset_pin_oe) else $error("pin driven early");
   por_wait_a:
      assert property (access_s |-> por_reg >= POR_WAIT_CYC) else $error("access too early");
   man_wait_a:
      assert property (access_s |-> gap_reg >= MAN_WAIT_CYC && !reset_pin)
         else $error("access too soon after pulse");
   ready_seen_a:
      assert property (access_s |-> seen_reg) else $error("access before clock activity");
endmodule
